// >>> rtl/sac_pkg.sv
// Shared constants, types and decode for the serial converter control block.
// Assumes a 250 MHz system clock; every pin input arrives asynchronously.
package sac_pkg;

  localparam int RES_BITS  = 10;
  localparam int ADDR_BITS = 4;
  localparam int CHANNELS  = 14;
  localparam int CNT_W     = 5;

  // Serial clock edge counts; the _PRE and _LAST values are the count before the edge
  localparam logic [CNT_W-1:0] RISE_ADDR_LAST = 5'h03;
  localparam logic [CNT_W-1:0] RISE_ADDR_DONE = 5'h04;
  localparam logic [CNT_W-1:0] FALL_SAMPLE_PRE = 5'h03;
  localparam logic [CNT_W-1:0] FALL_SAMPLE    = 5'h04;
  localparam logic [CNT_W-1:0] FALL_HOLD_PRE  = 5'h09;
  localparam logic [CNT_W-1:0] FALL_HOLD      = 5'h0a;
  localparam logic [CNT_W-1:0] RISE_SLOW_PRE  = 5'h0a;
  localparam logic [CNT_W-1:0] FALL_FRAME_PRE = 5'h0f;
  localparam logic [CNT_W-1:0] CLOCKS_MAX     = 5'h10;

  // Channel codes
  localparam logic [ADDR_BITS-1:0] ADDR_LAST_EXT = 4'ha;
  localparam logic [ADDR_BITS-1:0] ADDR_MID_REF  = 4'hb;
  localparam logic [ADDR_BITS-1:0] ADDR_LOW_REF  = 4'hc;
  localparam logic [ADDR_BITS-1:0] ADDR_HIGH_REF = 4'hd;
  localparam logic [ADDR_BITS-1:0] ADDR_RESET    = 4'h0;

  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int STEP_TIME_NS  = 2000;
  localparam int STEP_CYCLES   = STEP_TIME_NS / CLK_PERIOD_NS;
  localparam int BBM_TIME_NS   = 20;
  localparam logic [3:0] BBM_CYCLES =
    4'((BBM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Reset values
  localparam logic [RES_BITS-1:0] RESULT_RESET = 10'h000;
  localparam logic [3:0]          SYNC_RESET   = 4'h1;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_XFER = 4'b0010,
    ST_CONV = 4'b0100,
    ST_TAIL = 4'b1000
  } sac_state_t;

  typedef struct packed {
    logic cmp_below;
    logic addr;
    logic io_clk;
    logic cs_n;
  } sac_link_t;

  // Codes 0..13 map straight onto switch positions; 14 and 15 close none
  function automatic logic [CHANNELS-1:0] chan_decode(
    input logic [ADDR_BITS-1:0] code);
    logic [CHANNELS-1:0] oh;
    oh = '0;
    if (code <= ADDR_HIGH_REF) begin
      oh = {{(CHANNELS-1){1'b0}}, 1'b1} << code;
    end
    return oh;
  endfunction

  localparam logic [CHANNELS-1:0] CHSEL_RESET = 14'h0001;

endpackage

// >>> rtl/sac_sync.sv
// Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes the levels are slow against the clock; no pulse stretching.
`timescale 1ns/100ps
module sac_sync #(
  parameter int         WIDTH   = 4,
  parameter logic [3:0] RST_VAL = 4'h0
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta <= WIDTH'(RST_VAL);
      q_o  <= WIDTH'(RST_VAL);
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule

// >>> rtl/sac_sar.sv
// Successive-approximation sequencer: one trial weight per paced step.
// Assumes the comparator input is already synchronised and has settled
// within a step.
`timescale 1ns/100ps
module sac_sar #(
  parameter int BITS = 10,
  parameter int STEP = 500
) (
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            start_i,
  input  wire logic            abort_i,
  input  wire logic            cmp_below_i,
  output logic      [BITS-1:0] trial_o,
  output logic      [BITS-1:0] result_o,
  output logic                 done_o,
  output logic                 busy_o
);

  localparam int CW = $clog2(STEP + 1);

  logic [BITS-1:0] mask;
  logic [CW-1:0]   cnt;
  logic [BITS-1:0] next_trial, next_result, next_mask, resolved;
  logic [CW-1:0]   next_cnt;
  logic            next_busy, next_done;

  always_comb begin
    next_trial  = trial_o;
    next_result = result_o;
    next_mask   = mask;
    next_cnt    = cnt;
    next_busy   = busy_o;
    next_done   = 1'b0;
    // Keep the trial weight only when the node sits below the threshold
    resolved = cmp_below_i ? trial_o : (trial_o & ~mask);
    if (abort_i) begin
      next_busy  = 1'b0;
      next_trial = '0;
    end else if (start_i) begin
      next_busy  = 1'b1;
      next_mask  = {1'b1, {(BITS-1){1'b0}}};
      next_trial = {1'b1, {(BITS-1){1'b0}}};
      next_cnt   = '0;
    end else if (busy_o) begin
      if (cnt == CW'(STEP - 1)) begin
        next_cnt = '0;
        if (mask[0]) begin
          next_busy   = 1'b0;
          next_done   = 1'b1;
          next_trial  = resolved;
          next_result = resolved;
        end else begin
          next_mask  = mask >> 1;
          next_trial = resolved | (mask >> 1);
        end
      end else begin
        next_cnt = cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      trial_o  <= '0;
      result_o <= '0;
      mask     <= '0;
      cnt      <= '0;
      busy_o   <= 1'b0;
      done_o   <= 1'b0;
    end else begin
      trial_o  <= next_trial;
      result_o <= next_result;
      mask     <= next_mask;
      cnt      <= next_cnt;
      busy_o   <= next_busy;
      done_o   <= next_done;
    end
  end

  a_sar_keep_bit : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (busy_o && cnt == CW'(STEP - 1) && cmp_below_i && !abort_i && !start_i)
    |=> ((trial_o & $past(mask)) == $past(mask)))
    else $error("trial bit dropped while below threshold");

  a_sar_clear_bit : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (busy_o && cnt == CW'(STEP - 1) && !cmp_below_i && !abort_i && !start_i)
    |=> ((trial_o & $past(mask)) == '0))
    else $error("trial bit kept while above threshold");

endmodule

// >>> rtl/sac_ctrl.sv
// Serial control and sequencing of a 10-bit successive-approximation
// converter: chip select, serial clock, address in, result out, end flag.
// Assumes all link pins are asynchronous to CLOCK_I and much slower.
`timescale 1ns/100ps

// Summary of operation
// - Previous MSB shown at mode start edge
// - Nine further bits on next falling edges
// - End flag low at 10th fall, high done
// - Data forced low from 10th fall
// - Select fall enables data output
// - Select rise floats output, stops inputs
// - Conversion starts only at 10th fall
// - End flag rise presents new MSB
// - Mode six: 16th fall presents MSB
// - Slow: 11th rise before done, else resync
// - Address captured MSB first, four rises
// - Codes 0 to 10 pick inputs
// - Codes 11 to 13 pick references
// - Sample from 4th to 10th fall
// - Selector breaks before making
// - Ten bits MSB first, keep if below
// - Select fall aborts, result kept
// - Address ignored after four bits
module sac_ctrl #(
  parameter int STEP_CYCLES = sac_pkg::STEP_CYCLES
) (
  input  wire logic                         CLOCK_I,
  input  wire logic                         RST_N_I,
  input  wire logic                         CS_N_I,
  input  wire logic                         IO_CLK_I,
  input  wire logic                         ADDR_I,
  input  wire logic                         CMP_BELOW_I,
  output logic                              DOUT_O,
  output logic                              DOUT_OE_O,
  output logic                              EOC_O,
  output logic                              SAMPLE_O,
  output logic [sac_pkg::CHANNELS-1:0]      MUX_SEL_O,
  output logic [sac_pkg::RES_BITS-1:0]      TRIAL_O
);

  if (STEP_CYCLES < 1) begin : g_bad_step
    $error("STEP_CYCLES must be at least one");
  end

  sac_pkg::sac_link_t                 link_raw;
  sac_pkg::sac_link_t                 link_s;
  sac_pkg::sac_link_t                 link_q;
  sac_pkg::sac_state_t                state, next_state;
  logic [sac_pkg::CNT_W-1:0]          fall_cnt, next_fall;
  logic [sac_pkg::CNT_W-1:0]          rise_cnt, next_rise;
  logic [sac_pkg::ADDR_BITS-1:0]      addr_sr, next_addr_sr;
  logic [sac_pkg::ADDR_BITS-1:0]      addr_cur, next_addr_cur;
  logic [sac_pkg::RES_BITS-1:0]       shreg, next_shreg;
  logic [sac_pkg::RES_BITS-1:0]       result, next_result;
  logic [sac_pkg::RES_BITS-1:0]       sar_result;
  logic                               next_oe, next_eoc, next_sample;
  logic                               start, next_start;
  logic                               abort, next_abort;
  logic                               long_xfer, next_long;
  logic                               sar_done;
  logic                               cs_fall, io_rise, io_fall;
  logic [sac_pkg::ADDR_BITS-1:0]      applied, next_applied;
  logic [3:0]                         bbm_cnt, next_bbm;
  logic [sac_pkg::CHANNELS-1:0]       next_mux_sel;

  assign link_raw = '{cmp_below: CMP_BELOW_I, addr: ADDR_I,
                      io_clk: IO_CLK_I, cs_n: CS_N_I};

  // All pin levels, comparator included, cross through two flops
  sac_sync #(
    .WIDTH   (4),
    .RST_VAL (sac_pkg::SYNC_RESET)
  ) u_sync (
    .clk_i   (CLOCK_I),
    .rst_n_i (RST_N_I),
    .d_i     (link_raw),
    .q_o     (link_s)
  );

  sac_sar #(
    .BITS (sac_pkg::RES_BITS),
    .STEP (STEP_CYCLES)
  ) u_sar (
    .clk_i       (CLOCK_I),
    .rst_n_i     (RST_N_I),
    .start_i     (start),
    .abort_i     (abort),
    .cmp_below_i (link_s.cmp_below),
    .trial_o     (TRIAL_O),
    .result_o    (sar_result),
    .done_o      (sar_done),
    .busy_o      ()
  );

  // Edges are found on the second synchroniser stage only
  assign cs_fall = link_q.cs_n & ~link_s.cs_n;
  assign io_rise = ~link_q.io_clk & link_s.io_clk;
  assign io_fall = link_q.io_clk & ~link_s.io_clk;

  assign DOUT_O = shreg[sac_pkg::RES_BITS-1];

  // Sequencer
  always_comb begin
    next_state    = state;
    next_fall     = fall_cnt;
    next_rise     = rise_cnt;
    next_addr_sr  = addr_sr;
    next_addr_cur = addr_cur;
    next_shreg    = shreg;
    next_result   = result;
    next_oe       = DOUT_OE_O;
    next_eoc      = EOC_O;
    next_sample   = SAMPLE_O;
    next_start    = 1'b0;
    next_abort    = 1'b0;
    next_long     = long_xfer;
    if (sar_done) begin
      next_result = sar_result;
      next_eoc    = 1'b1;
    end
    if (cs_fall) begin
      // A new frame always restarts; a running conversion is dropped
      next_abort  = (state == sac_pkg::ST_CONV);
      next_eoc    = 1'b1;
      next_state  = sac_pkg::ST_XFER;
      next_fall   = '0;
      next_rise   = '0;
      next_sample = 1'b0;
      next_long   = 1'b0;
      next_oe     = 1'b1;
      next_shreg  = result;
    end else if (link_s.cs_n) begin
      // Clock and address are ignored while select is high
      next_oe     = 1'b0;
      next_sample = 1'b0;
      if (state != sac_pkg::ST_CONV || sar_done) begin
        next_state = sac_pkg::ST_IDLE;
      end
    end else begin
      if (io_rise && rise_cnt != sac_pkg::CLOCKS_MAX) begin
        next_rise = rise_cnt + 5'h01;
      end
      if (io_rise && state == sac_pkg::ST_XFER &&
          rise_cnt < sac_pkg::RISE_ADDR_DONE) begin
        next_addr_sr = {addr_sr[sac_pkg::ADDR_BITS-2:0], link_s.addr};
        if (rise_cnt == sac_pkg::RISE_ADDR_LAST) begin
          next_addr_cur = {addr_sr[sac_pkg::ADDR_BITS-2:0], link_s.addr};
        end
      end
      // An 11th rise seen during conversion marks a long transfer
      if (io_rise && state == sac_pkg::ST_CONV &&
          rise_cnt == sac_pkg::RISE_SLOW_PRE) begin
        next_long = 1'b1;
      end
      if (io_fall && fall_cnt != sac_pkg::CLOCKS_MAX) begin
        next_fall = fall_cnt + 5'h01;
      end
      unique case (state)
        sac_pkg::ST_IDLE: begin
          next_state = sac_pkg::ST_IDLE;
        end
        sac_pkg::ST_XFER: begin
          if (io_fall && fall_cnt == sac_pkg::FALL_HOLD_PRE) begin
            next_shreg  = '0;
            next_eoc    = 1'b0;
            next_sample = 1'b0;
            next_start  = 1'b1;
            next_long   = 1'b0;
            next_state  = sac_pkg::ST_CONV;
          end else if (io_fall) begin
            next_shreg = shreg << 1;
            if (fall_cnt == sac_pkg::FALL_SAMPLE_PRE) begin
              next_sample = 1'b1;
            end
          end
        end
        sac_pkg::ST_CONV: begin
          if (sar_done) begin
            if (long_xfer && fall_cnt != sac_pkg::CLOCKS_MAX) begin
              // Slow transfer: wait for the frame's 16th fall
              next_state = sac_pkg::ST_TAIL;
            end else begin
              // Continuous select: the end-flag rise opens the next frame
              next_state = sac_pkg::ST_XFER;
              next_fall  = '0;
              next_rise  = '0;
              next_shreg = sar_result;
            end
          end
        end
        sac_pkg::ST_TAIL: begin
          if (io_fall && fall_cnt == sac_pkg::FALL_FRAME_PRE) begin
            next_state = sac_pkg::ST_XFER;
            next_fall  = '0;
            next_rise  = '0;
            next_shreg = result;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      link_q    <= sac_pkg::SYNC_RESET;
      state     <= sac_pkg::ST_IDLE;
      fall_cnt  <= '0;
      rise_cnt  <= '0;
      addr_sr   <= sac_pkg::ADDR_RESET;
      addr_cur  <= sac_pkg::ADDR_RESET;
      shreg     <= sac_pkg::RESULT_RESET;
      result    <= sac_pkg::RESULT_RESET;
      DOUT_OE_O <= 1'b0;
      EOC_O     <= 1'b1;
      SAMPLE_O  <= 1'b0;
      start     <= 1'b0;
      abort     <= 1'b0;
      long_xfer <= 1'b0;
    end else begin
      link_q    <= link_s;
      state     <= next_state;
      fall_cnt  <= next_fall;
      rise_cnt  <= next_rise;
      addr_sr   <= next_addr_sr;
      addr_cur  <= next_addr_cur;
      shreg     <= next_shreg;
      result    <= next_result;
      DOUT_OE_O <= next_oe;
      EOC_O     <= next_eoc;
      SAMPLE_O  <= next_sample;
      start     <= next_start;
      abort     <= next_abort;
      long_xfer <= next_long;
    end
  end

  // Input selector: open everything for a short gap, then close the new
  // switch. Codes with no switch still convert a defined ten-bit word.
  always_comb begin
    next_mux_sel = MUX_SEL_O;
    next_applied = applied;
    next_bbm     = bbm_cnt;
    if (bbm_cnt != 4'h0) begin
      next_bbm = bbm_cnt - 4'h1;
      if (bbm_cnt == 4'h1) begin
        next_mux_sel = sac_pkg::chan_decode(addr_cur);
        next_applied = addr_cur;
      end
    end else if (addr_cur != applied) begin
      next_mux_sel = '0;
      next_bbm     = sac_pkg::BBM_CYCLES;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      MUX_SEL_O <= sac_pkg::CHSEL_RESET;
      applied   <= sac_pkg::ADDR_RESET;
      bbm_cnt   <= 4'h0;
    end else begin
      MUX_SEL_O <= next_mux_sel;
      applied   <= next_applied;
      bbm_cnt   <= next_bbm;
    end
  end

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_N_I);

  a_msb_on_select : assert property (cs_fall && !sar_done |=>
    DOUT_OE_O && DOUT_O == result[sac_pkg::RES_BITS-1])
    else $error("MSB not presented after select fall");

  a_eoc_tenth_fall : assert property (
    state == sac_pkg::ST_XFER && io_fall && !link_s.cs_n && !cs_fall &&
    fall_cnt == sac_pkg::FALL_HOLD_PRE |=> !EOC_O && start)
    else $error("end flag not low at tenth fall");

  a_dout_low_conv : assert property (
    state == sac_pkg::ST_CONV |-> !DOUT_O)
    else $error("data not held low during conversion");

  a_float_on_high : assert property (
    link_s.cs_n && !cs_fall |=> !DOUT_OE_O)
    else $error("data output still driven with select high");

  a_start_tenth : assert property (
    start |-> fall_cnt == sac_pkg::FALL_HOLD)
    else $error("conversion started away from tenth fall");

  a_eoc_rise_msb : assert property (
    state == sac_pkg::ST_CONV && sar_done && !long_xfer &&
    !link_s.cs_n && !cs_fall |=>
    state == sac_pkg::ST_XFER && EOC_O &&
    DOUT_O == $past(sar_result[sac_pkg::RES_BITS-1]))
    else $error("new MSB missing at end flag rise");

  a_tail_msb : assert property (
    state == sac_pkg::ST_TAIL && io_fall && !link_s.cs_n && !cs_fall &&
    fall_cnt == sac_pkg::FALL_FRAME_PRE |=>
    fall_cnt == '0 && DOUT_O == result[sac_pkg::RES_BITS-1])
    else $error("MSB missing after sixteenth fall");

  a_sample_window : assert property (
    $rose(SAMPLE_O) |-> fall_cnt == sac_pkg::FALL_SAMPLE &&
    state == sac_pkg::ST_XFER)
    else $error("sampling opened at wrong edge");

  a_break_first : assert property (
    MUX_SEL_O != '0 && $changed(MUX_SEL_O) |->
    $past(MUX_SEL_O) == '0)
    else $error("selector made before break");

  a_addr_frozen : assert property (
    $changed(addr_cur) |-> rise_cnt == sac_pkg::RISE_ADDR_DONE)
    else $error("address changed outside its four rises");

  a_abort_keeps : assert property (
    cs_fall && state == sac_pkg::ST_CONV && !sar_done |=>
    $stable(result) && abort && EOC_O)
    else $error("abort lost previous result");

  c_frame_end_high : cover property (
    state == sac_pkg::ST_CONV && sar_done && link_s.cs_n);
  c_frame_continuous : cover property (
    state == sac_pkg::ST_CONV && sar_done && !long_xfer && !link_s.cs_n);
  c_frame_tail : cover property (state == sac_pkg::ST_TAIL ##1
    state == sac_pkg::ST_XFER);
  c_abort : cover property (cs_fall && state == sac_pkg::ST_CONV);

endmodule

// >>> bench/sac_host_model.sv
// Host serial port model: drives select, serial clock and address.
// Assumes the bench calls frame() from one thread; serial period 32 ns.
`timescale 1ns/100ps
module sac_host_model (
  input  wire logic clk_i,
  input  wire logic dout_i,
  input  wire logic dout_oe_i,
  input  wire logic eoc_i,
  output logic      cs_n_o,
  output logic      io_clk_o,
  output logic      addr_o
);
  logic drive;
  logic bit_val;
  logic junk;
  logic hang;

  initial begin
    cs_n_o   = 1'b1;
    io_clk_o = 1'b0;
    drive    = 1'b0;
    bit_val  = 1'b0;
    junk     = 1'b0;
    hang     = 1'b0;
  end

  // Outside the address bits the line carries a changing pattern
  always @(negedge clk_i) junk <= ~junk;
  assign addr_o = drive ? bit_val : junk;

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic frame(input logic [3:0] code, input int n, input bit slow,
                       input bit keep, output logic [9:0] res,
                       output logic [5:0] tail, output logic oe_ok);
    int g;
    res   = '0;
    tail  = '0;
    oe_ok = 1'b1;
    if (cs_n_o) begin
      @(negedge clk_i);
      cs_n_o = 1'b0;
      // Select setup before the first clock
      wait_clk(8);
    end
    for (int i = 1; i <= n; i++) begin
      drive = (i <= 4);
      if (i <= 4) bit_val = code[4-i];
      wait_clk(4);
      if (i <= 10) res[10-i] = dout_i;
      else tail[16-i] = dout_i;
      oe_ok &= dout_oe_i;
      io_clk_o = 1'b1;
      wait_clk(4);
      g = 0;
      while (slow && i == 11 && !eoc_i && g < 4000) begin
        wait_clk(1);
        g++;
      end
      if (g >= 4000) hang = 1'b1;
      io_clk_o = 1'b0;
    end
    drive = 1'b0;
    wait_clk(4);
    if (!keep) begin
      cs_n_o = 1'b1;
      wait_clk(8);
    end
  endtask
endmodule

// >>> bench/sac_ctrl_tb_top.sv
// Self-checking bench for the serial converter control block.
// Assumes a host model on the link and a comparator model on the array.
`timescale 1ns/100ps
module sac_ctrl_tb_top;
  localparam int STEP = 16;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        cmp_below;
  logic        cs_n;
  logic        io_clk;
  logic        addr_bit;
  logic        dout;
  logic        dout_oe;
  logic        eoc;
  logic        sample;
  logic [13:0] mux_sel;
  logic [13:0] last_sel = 14'h0000;
  logic [9:0]  trial;
  logic [9:0]  prev_exp = sac_pkg::RESULT_RESET;
  logic [9:0]  res;
  logic [5:0]  tail;
  logic        oe_ok;
  int          fail_count = 0;
  int          tests_run = 0;
  int          samp_cnt = 0;
  int          eoc_lo = 0;
  int          eoc_len = 0;
  int          bbm_bad = 0;

  always #2 clock = ~clock;

  // Input level per code; 14 stands for all switches open
  function automatic logic [9:0] level_of(input int ch);
    case (ch)
      11: return 10'h200;
      12: return 10'h000;
      13: return 10'h3ff;
      14, 15: return 10'h155;
      default: return 10'(ch) * 10'h04d + 10'h005;
    endcase
  endfunction

  always_comb begin
    cmp_below = trial <= level_of(14);
    for (int c = 0; c < 14; c++) begin
      if (mux_sel[c]) cmp_below = trial <= level_of(c);
    end
  end

  always @(posedge clock) begin
    if (sample) samp_cnt <= samp_cnt + 1;
    if (!eoc) eoc_lo <= eoc_lo + 1;
    else if (eoc_lo != 0) begin
      eoc_len <= eoc_lo;
      eoc_lo  <= 0;
    end
    last_sel <= mux_sel;
    if (last_sel != 0 && mux_sel != 0 && mux_sel != last_sel) begin
      bbm_bad <= bbm_bad + 1;
    end
  end

  sac_ctrl #(.STEP_CYCLES(STEP)) dut_u (
    .CLOCK_I     (clock),
    .RST_N_I     (rst_n),
    .CS_N_I      (cs_n),
    .IO_CLK_I    (io_clk),
    .ADDR_I      (addr_bit),
    .CMP_BELOW_I (cmp_below),
    .DOUT_O      (dout),
    .DOUT_OE_O   (dout_oe),
    .EOC_O       (eoc),
    .SAMPLE_O    (sample),
    .MUX_SEL_O   (mux_sel),
    .TRIAL_O     (trial)
  );

  sac_host_model host_u (
    .clk_i     (clock),
    .dout_i    (dout),
    .dout_oe_i (dout_oe),
    .eoc_i     (eoc),
    .cs_n_o    (cs_n),
    .io_clk_o  (io_clk),
    .addr_o    (addr_bit)
  );

  task automatic cmp_res(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: value %h not %h", $time, got, exp);
    end
  endtask

  task automatic cmp_sel(input logic [13:0] got, input logic [13:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: select %h not %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: flag %b not %b", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("fail_count=%0d tests_run=%0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wait_eoc();
    int g;
    g = 0;
    while (eoc !== 1'b1 && g < 4000) begin
      @(negedge clock);
      g++;
    end
    if (g >= 4000 || host_u.hang) begin
      fail_count++;
      $display("unexpected at %0t: wait ran out", $time);
      end_of_test();
    end
  endtask

  // One transfer, then its checks; the result read is the one before
  task automatic run(input logic [3:0] code, input int n, input bit slow,
                     input bit keep);
    logic [13:0] exp_sel;
    int          s0;
    exp_sel = (code <= 4'hd) ? 14'h0001 << code : 14'h0000;
    // The counter has a single driver; this transfer's share is the delta
    s0 = samp_cnt;
    host_u.frame(code, n, slow, keep, res, tail, oe_ok);
    cmp_res(res, prev_exp);
    cmp_res(10'(tail), 10'h000);
    cmp_bit(oe_ok, 1'b1);
    cmp_bit(dout_oe, keep);
    cmp_bit(samp_cnt - s0 >= 47 && samp_cnt - s0 <= 49, 1'b1);
    cmp_sel(mux_sel, exp_sel);
    if (!slow) cmp_bit(eoc, 1'b0);
    wait_eoc();
    @(negedge clock);
    cmp_res(10'(eoc_len), 10'(10 * STEP + 2));
    prev_exp = level_of(int'(code));
  endtask

  task automatic t_reset();
    repeat (16) @(negedge clock);
    cmp_bit(eoc, 1'b1);
    cmp_bit(dout_oe, 1'b0);
    cmp_bit(sample, 1'b0);
    cmp_sel(mux_sel, sac_pkg::CHSEL_RESET);
    cmp_res(trial, 10'h000);
    rst_n = 1'b1;
  endtask

  task automatic t_mode1();
    for (int c = 0; c < 16; c++) run(4'(c), 10, 1'b0, 1'b0);
  endtask

  task automatic t_mode3();
    for (int n = 11; n <= 16; n++) run(4'(n - 6), n, 1'b0, 1'b0);
  endtask

  task automatic t_slow();
    run(4'hd, 11, 1'b1, 1'b0);
    run(4'hc, 16, 1'b1, 1'b0);
  endtask

  // Select falls again while the second conversion is running
  task automatic t_abort();
    run(4'h2, 10, 1'b0, 1'b0);
    host_u.frame(4'h7, 10, 1'b0, 1'b0, res, tail, oe_ok);
    cmp_bit(eoc, 1'b0);
    run(4'h3, 10, 1'b0, 1'b0);
    run(4'h0, 10, 1'b0, 1'b0);
  endtask

  // Select held low through fast short, fast long and slow long frames
  task automatic t_held();
    run(4'h1, 10, 1'b0, 1'b1);
    run(4'h2, 10, 1'b0, 1'b1);
    run(4'hb, 16, 1'b0, 1'b1);
    run(4'h9, 16, 1'b0, 1'b1);
    run(4'hd, 16, 1'b1, 1'b1);
    run(4'h3, 16, 1'b1, 1'b1);
    run(4'h0, 16, 1'b1, 1'b0);
  endtask

  initial begin
    t_reset();
    t_mode1();
    t_mode3();
    t_slow();
    t_abort();
    t_held();
    cmp_res(10'(bbm_bad), 10'h000);
    end_of_test();
  end
endmodule
